// *** core/monitor_map.svh ***
`ifndef MONITOR_MAP_SVH
`define MONITOR_MAP_SVH

// ==========================================================
// Register offsets
`define ADDR_STATUS_ONE 8'h41
`define ADDR_HOT_LIMIT 8'h39
`define ADDR_HYST_LIMIT 8'h3A
`define ADDR_INTRUSION_CLEAR 8'h46
`define ADDR_VOLTAGE_ID_FAN 8'h47
`define ADDR_SERIAL_ADDRESS 8'h48
`define ADDR_VOLTAGE_ID_HIGH 8'h49
`define ADDR_TEMP_CONFIG 8'h4B

// ==========================================================
// Field positions
`define INTRUSION_CLEAR_BIT 7
`define TEMP_ERROR_BIT 4
`define TEMP_NINTH_BIT 7

// ==========================================================
// Reset values
`define RESET_INTRUSION_CLEAR 8'h00
`define RESET_FAN_DIVISORS 4'h0
`define SERIAL_ADDRESS_PREFIX 6'h0B
`define RESET_SERIAL_ADDRESS 8'h2C
`define RESET_VOLTAGE_ID_HIGH 7'h40
`define RESET_TEMP_CONFIG 8'h01
`define RESET_HOT_LIMIT 8'h7F
`define RESET_HYST_LIMIT 8'h7F

// ==========================================================
// Timing
`define CLOCK_HZ 100000000
`define INTRUSION_PULSE_MS 20
`define INTRUSION_PULSE_CYCLES \
    ((`CLOCK_HZ / 1000) * `INTRUSION_PULSE_MS)
`define STRAP_SETTLE_CYCLES 2'h3

`endif

// *** core/monitor_pkg.sv ***
package monitor_pkg;

    // ======================================================
    // Temperature interrupt modes, decoded from config bits 1:0
    typedef enum {
        temp_mode_default,
        temp_mode_one_time,
        temp_mode_comparator
    } temp_mode_type;

    // ======================================================
    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wr_data;
        logic wr_en;
        logic rd_en;
    } reg_request_type;

    // ======================================================
    // Writable register contents
    typedef struct packed {
        logic intrusion_clear;
        logic [1:0] first_divisor;
        logic [1:0] second_divisor;
        logic [7:0] serial_address;
        logic [6:0] voltage_id_spare;
        logic [6:0] temp_config;
        logic [7:0] hot_limit;
        logic [7:0] hyst_limit;
    } reg_file_type;

    // ======================================================
    // Temperature measurement from the converter
    typedef struct packed {
        logic done;
        logic [8:0] value;
    } temp_sample_type;

endpackage

// *** core/tach_divider.sv ***
`timescale 1ns/10ps
`include "monitor_map.svh"

module tach_divider
    import monitor_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Tach edges and divisor select
    input wire logic tach_edge,
    input wire logic [1:0] divisor_select,
    // Divided pulse
    output logic tach_pulse
);

    logic [2:0] edge_count;
    logic [2:0] next_edge_count;
    logic [1:0] divisor_active;
    logic [1:0] next_divisor_active;
    logic next_tach_pulse;

    // ======================================================
    // Divide by 1, 2, 4 or 8
    function automatic logic [2:0] divisor_top(input logic [1:0] sel);
        case (sel)
            2'h0: divisor_top = 3'h0;
            2'h1: divisor_top = 3'h1;
            2'h2: divisor_top = 3'h3;
            default: divisor_top = 3'h7;
        endcase
    endfunction

    always_comb begin
        next_edge_count = edge_count;
        next_divisor_active = divisor_active;
        next_tach_pulse = 1'b0;
        if (tach_edge) begin
            if (edge_count >= divisor_top(divisor_active)) begin
                next_edge_count = 3'h0;
                next_tach_pulse = 1'b1;
                // Divisor only changes at a period boundary
                next_divisor_active = divisor_select;
            end else begin
                next_edge_count = edge_count + 3'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            edge_count <= 3'h0;
            divisor_active <= 2'(`RESET_FAN_DIVISORS);
            tach_pulse <= 1'b0;
        end else begin
            edge_count <= next_edge_count;
            divisor_active <= next_divisor_active;
            tach_pulse <= next_tach_pulse;
        end
    end

endmodule

// *** core/monitor_config_registers.sv ***
`timescale 1ns/10ps
`include "monitor_map.svh"

module monitor_config_registers
    import monitor_pkg::*;
#(
    parameter int unsigned INTRUSION_PULSE_CYCLES = `INTRUSION_PULSE_CYCLES
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Register port from the two-wire interface
    input wire reg_request_type reg_request,
    output logic [7:0] reg_rd_data,
    // Serial address to the two-wire interface
    output logic [7:0] serial_bus_address,
    // Pins
    input wire logic [3:0] cpu_voltage_code,
    input wire logic cpu_voltage_code_bit4,
    input wire logic addr_select_low,
    input wire logic addr_select_high,
    input wire logic first_tach_input,
    input wire logic second_tach_input,
    input wire logic intrusion_detect_pin_in,
    output logic intrusion_detect_pin_out,
    output logic intrusion_detect_pin_oe,
    output logic intrusion_flag_clear,
    // Temperature converter
    input wire temp_sample_type temp_sample,
    // Monitor outputs
    output logic temp_error_flag,
    output logic system_mgmt_alert,
    output logic first_fan_pulse,
    output logic second_fan_pulse
);

    // ======================================================
    // Pin synchronisers: three stages, change accepted once
    // stages two and three agree
    localparam int PIN_COUNT = 10;
    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] sync_one;
    logic [PIN_COUNT-1:0] sync_two;
    logic [PIN_COUNT-1:0] sync_three;
    logic [PIN_COUNT-1:0] pin_level;
    logic [PIN_COUNT-1:0] next_pin_level;

    assign pin_raw = {intrusion_detect_pin_in, second_tach_input,
                      first_tach_input, addr_select_high,
                      addr_select_low, cpu_voltage_code_bit4,
                      cpu_voltage_code};

    always_comb begin
        next_pin_level = pin_level;
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (sync_two[i] == sync_three[i]) begin
                next_pin_level[i] = sync_three[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sync_one <= '0;
            sync_two <= '0;
            sync_three <= '0;
            pin_level <= '0;
        end else begin
            sync_one <= pin_raw;
            sync_two <= sync_one;
            sync_three <= sync_two;
            pin_level <= next_pin_level;
        end
    end

    logic [3:0] voltage_code;
    logic voltage_code_bit4;
    logic [1:0] strap_level;
    logic [1:0] tach_level;
    logic [1:0] tach_prev;
    logic [1:0] tach_edge;

    assign voltage_code = pin_level[3:0];
    assign voltage_code_bit4 = pin_level[4];
    assign strap_level = pin_level[6:5];
    assign tach_level = pin_level[8:7];
    assign tach_edge = tach_level & ~tach_prev;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tach_prev <= 2'h0;
        end else begin
            tach_prev <= tach_level;
        end
    end

    // ======================================================
    // Register file and intrusion pulse timer
    reg_file_type regs;
    reg_file_type next_regs;
    logic [31:0] pulse_count;
    logic [31:0] next_pulse_count;
    logic [2:0] strap_wait;
    logic [2:0] next_strap_wait;
    logic write_hit;

    function automatic logic hit(input reg_request_type req,
                                 input logic [7:0] offset);
        hit = req.addr == offset;
    endfunction

    assign write_hit = reg_request.wr_en;

    always_comb begin
        next_regs = regs;
        next_pulse_count = pulse_count;
        next_strap_wait = strap_wait;
        // Straps settle through the synchroniser before capture
        if (strap_wait != 3'h0) begin
            next_strap_wait = strap_wait - 3'h1;
            if (strap_wait == 3'h1) begin
                next_regs.serial_address =
                    {`SERIAL_ADDRESS_PREFIX, strap_level};
            end
        end
        if (write_hit) begin
            if (hit(reg_request, `ADDR_INTRUSION_CLEAR)) begin
                next_regs.intrusion_clear =
                    reg_request.wr_data[`INTRUSION_CLEAR_BIT];
            end
            if (hit(reg_request, `ADDR_VOLTAGE_ID_FAN)) begin
                // Bits 3:0 are pin readback and are not stored
                next_regs.first_divisor = reg_request.wr_data[5:4];
                next_regs.second_divisor = reg_request.wr_data[7:6];
            end
            if (hit(reg_request, `ADDR_SERIAL_ADDRESS)) begin
                next_regs.serial_address = reg_request.wr_data;
            end
            if (hit(reg_request, `ADDR_VOLTAGE_ID_HIGH)) begin
                next_regs.voltage_id_spare = reg_request.wr_data[7:1];
            end
            if (hit(reg_request, `ADDR_TEMP_CONFIG)) begin
                // Bit 7 is the ninth temperature bit, read only
                next_regs.temp_config = reg_request.wr_data[6:0];
            end
            if (hit(reg_request, `ADDR_HOT_LIMIT)) begin
                next_regs.hot_limit = reg_request.wr_data;
            end
            if (hit(reg_request, `ADDR_HYST_LIMIT)) begin
                next_regs.hyst_limit = reg_request.wr_data;
            end
        end
        // A write of one during a pulse does not restart it
        if (regs.intrusion_clear) begin
            if (pulse_count >= INTRUSION_PULSE_CYCLES - 1) begin
                next_pulse_count = 32'h0;
                next_regs.intrusion_clear = 1'b0;
            end else begin
                next_pulse_count = pulse_count + 32'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            regs.intrusion_clear <= 1'(`RESET_INTRUSION_CLEAR);
            regs.first_divisor <= 2'h0;
            regs.second_divisor <= 2'h0;
            regs.serial_address <= `RESET_SERIAL_ADDRESS;
            regs.voltage_id_spare <= `RESET_VOLTAGE_ID_HIGH;
            regs.temp_config <= 7'(`RESET_TEMP_CONFIG);
            regs.hot_limit <= `RESET_HOT_LIMIT;
            regs.hyst_limit <= `RESET_HYST_LIMIT;
            pulse_count <= 32'h0;
            strap_wait <= {1'b1, `STRAP_SETTLE_CYCLES};
        end else begin
            regs <= next_regs;
            pulse_count <= next_pulse_count;
            strap_wait <= next_strap_wait;
        end
    end

    // Open drain: only ever pulls low
    assign intrusion_detect_pin_out = 1'b0;
    assign intrusion_detect_pin_oe = regs.intrusion_clear;
    // Intrusion flag is cleared only by this pulse, never by a read
    assign intrusion_flag_clear = regs.intrusion_clear;
    assign serial_bus_address = regs.serial_address;

    // ======================================================
    // Temperature interrupt logic
    temp_mode_type temp_mode;
    logic status_read;
    logic above_hot;
    logic below_hyst;
    logic hot_latched;
    logic next_hot_latched;
    logic next_temp_error_flag;
    logic temp_set;
    logic temp_clear;
    logic [7:0] temp_whole;

    always_comb begin
        // Equal mode bits select the default mode
        case (regs.temp_config[1:0])
            2'h1: temp_mode = temp_mode_one_time;
            2'h2: temp_mode = temp_mode_comparator;
            default: temp_mode = temp_mode_default;
        endcase
    end

    // Two's complement temperature against signed limits
    assign temp_whole = temp_sample.value[8:1];
    assign above_hot = $signed(temp_whole) > $signed(regs.hot_limit);
    assign below_hyst = $signed(temp_whole) < $signed(regs.hyst_limit);
    assign status_read = reg_request.rd_en &&
                         hit(reg_request, `ADDR_STATUS_ONE);

    always_comb begin
        next_hot_latched = hot_latched;
        temp_set = 1'b0;
        temp_clear = status_read;
        if (temp_sample.done) begin
            case (temp_mode)
                temp_mode_default: begin
                    if (above_hot) begin
                        next_hot_latched = 1'b1;
                        temp_set = 1'b1;
                    end else if (below_hyst) begin
                        next_hot_latched = 1'b0;
                    end else if (hot_latched) begin
                        temp_set = 1'b1;
                    end
                end
                temp_mode_one_time: begin
                    if (!hot_latched && above_hot) begin
                        next_hot_latched = 1'b1;
                        temp_set = 1'b1;
                    end else if (hot_latched && below_hyst) begin
                        next_hot_latched = 1'b0;
                        temp_set = 1'b1;
                    end
                    // Any other conversion leaves the flag alone
                end
                temp_mode_comparator: begin
                    next_hot_latched = above_hot;
                    if (above_hot) begin
                        temp_set = 1'b1;
                    end else begin
                        temp_clear = 1'b1;
                    end
                end
                default: begin
                    next_hot_latched = 1'b0;
                end
            endcase
        end
        // Set wins over a clear in the same cycle
        if (temp_set) begin
            next_temp_error_flag = 1'b1;
        end else if (temp_clear) begin
            next_temp_error_flag = 1'b0;
        end else begin
            next_temp_error_flag = temp_error_flag;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            hot_latched <= 1'b0;
            temp_error_flag <= 1'b0;
        end else begin
            hot_latched <= next_hot_latched;
            temp_error_flag <= next_temp_error_flag;
        end
    end

    assign system_mgmt_alert = temp_error_flag &&
                               temp_mode == temp_mode_comparator;

    // ======================================================
    // Ninth temperature bit, held from the last conversion
    logic temp_ninth;
    logic next_temp_ninth;

    always_comb begin
        next_temp_ninth = temp_ninth;
        if (temp_sample.done) begin
            next_temp_ninth = temp_sample.value[0];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            temp_ninth <= 1'b0;
        end else begin
            temp_ninth <= next_temp_ninth;
        end
    end

    // ======================================================
    // Read data, registered one cycle after the request
    logic [7:0] next_reg_rd_data;

    always_comb begin
        next_reg_rd_data = reg_rd_data;
        if (reg_request.rd_en) begin
            case (reg_request.addr)
                `ADDR_STATUS_ONE: begin
                    next_reg_rd_data = 8'h00;
                    next_reg_rd_data[`TEMP_ERROR_BIT] =
                        temp_error_flag;
                end
                `ADDR_HOT_LIMIT: next_reg_rd_data = regs.hot_limit;
                `ADDR_HYST_LIMIT: next_reg_rd_data = regs.hyst_limit;
                `ADDR_INTRUSION_CLEAR: begin
                    next_reg_rd_data = {regs.intrusion_clear, 7'h00};
                end
                `ADDR_VOLTAGE_ID_FAN: begin
                    next_reg_rd_data = {regs.second_divisor,
                                        regs.first_divisor,
                                        voltage_code};
                end
                `ADDR_SERIAL_ADDRESS: begin
                    next_reg_rd_data = regs.serial_address;
                end
                `ADDR_VOLTAGE_ID_HIGH: begin
                    next_reg_rd_data = {regs.voltage_id_spare,
                                        voltage_code_bit4};
                end
                `ADDR_TEMP_CONFIG: begin
                    next_reg_rd_data = {temp_ninth,
                                        regs.temp_config};
                end
                default: next_reg_rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rd_data <= 8'h00;
        end else begin
            reg_rd_data <= next_reg_rd_data;
        end
    end

    // ======================================================
    // Fan tach prescalers
    tach_divider first_divider (
        .clock(clock),
        .sys_rst(sys_rst),
        .tach_edge(tach_edge[0]),
        .divisor_select(regs.first_divisor),
        .tach_pulse(first_fan_pulse)
    );

    tach_divider second_divider (
        .clock(clock),
        .sys_rst(sys_rst),
        .tach_edge(tach_edge[1]),
        .divisor_select(regs.second_divisor),
        .tach_pulse(second_fan_pulse)
    );

endmodule

// *** sim/monitor_checker.sv ***
`timescale 1ns/10ps
module monitor_checker
    import monitor_pkg::*;
#(
    parameter int unsigned INTRUSION_PULSE_CYCLES = 20
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Register port
    input wire reg_request_type reg_request,
    input wire logic [7:0] reg_rd_data,
    input wire logic [7:0] serial_bus_address,
    // Pins
    input wire logic addr_select_low,
    input wire logic addr_select_high,
    input wire logic intrusion_detect_pin_out,
    input wire logic intrusion_detect_pin_oe,
    input wire logic intrusion_flag_clear,
    // Monitor
    input wire temp_sample_type temp_sample,
    input wire logic temp_error_flag,
    input wire logic system_mgmt_alert,
    input wire logic first_fan_pulse
);
    logic [31:0] low_cycles;
    logic [31:0] next_low_cycles;
    logic write_zero;
    logic write_one;
    logic status_read;

    // ========
    // Pulse length counter
    always_comb begin
        next_low_cycles = 32'h0;
        if (!sys_rst && intrusion_detect_pin_oe) begin
            next_low_cycles = low_cycles + 32'h1;
        end
    end
    always_ff @(posedge clock) begin
        low_cycles <= next_low_cycles;
    end
    assign write_one = reg_request.wr_en && reg_request.addr == 8'h46
        && reg_request.wr_data[7];
    // A zero write may cut the pulse short, so it is exempt
    assign write_zero = reg_request.wr_en && reg_request.addr == 8'h46
        && !reg_request.wr_data[7];
    assign status_read = reg_request.rd_en && reg_request.addr == 8'h41;

    // ========
    // Properties
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_quiet_release;
        $fell(sys_rst) ##0 (!reg_request.wr_en) [*6];
    endsequence

    a_pulse_start: assert property (
        write_one && !intrusion_detect_pin_oe |=> intrusion_detect_pin_oe)
        else $error("Intrusion pulse did not start");
    a_pulse_length: assert property (
        $fell(intrusion_detect_pin_oe) && !$past(write_zero)
        |-> low_cycles >= INTRUSION_PULSE_CYCLES)
        else $error("Intrusion pulse too short");
    a_flag_level: assert property (
        intrusion_detect_pin_oe |-> intrusion_flag_clear)
        else $error("Flag clear missing during pulse");
    a_pin_low: assert property (!intrusion_detect_pin_out)
        else $error("Intrusion pin drives high");
    a_status_clear: assert property (
        status_read && !temp_sample.done |=> !temp_error_flag)
        else $error("Status read did not clear flag");
    a_status_bits: assert property (
        status_read
        |=> reg_rd_data == {3'h0, $past(temp_error_flag), 4'h0})
        else $error("Status read data wrong");
    a_strap_load: assert property (
        s_quiet_release |=> ##1 serial_bus_address
        == {6'h0B, addr_select_high, addr_select_low})
        else $error("Bus address power-up value wrong");
    a_flag_cause: assert property (
        $rose(temp_error_flag) |-> $past(temp_sample.done))
        else $error("Flag set without conversion");
    a_alert_flag: assert property (
        system_mgmt_alert |-> temp_error_flag)
        else $error("Alert without temperature flag");
    a_fan_single: assert property (
        first_fan_pulse |=> !first_fan_pulse)
        else $error("Fan pulse longer than a cycle");
endmodule

bind monitor_config_registers monitor_checker #(
    .INTRUSION_PULSE_CYCLES(INTRUSION_PULSE_CYCLES)
) u_checker (
    .clock(clock), .sys_rst(sys_rst), .reg_request(reg_request),
    .reg_rd_data(reg_rd_data), .serial_bus_address(serial_bus_address),
    .addr_select_low(addr_select_low), .addr_select_high(addr_select_high),
    .intrusion_detect_pin_out(intrusion_detect_pin_out),
    .intrusion_detect_pin_oe(intrusion_detect_pin_oe),
    .intrusion_flag_clear(intrusion_flag_clear), .temp_sample(temp_sample),
    .temp_error_flag(temp_error_flag), .system_mgmt_alert(system_mgmt_alert),
    .first_fan_pulse(first_fan_pulse)
);

// *** sim/host_model.sv ***
`timescale 1ns/10ps
module host_model
    import monitor_pkg::*;
(
    // Clock
    input wire logic clock,
    // Register port
    output reg_request_type reg_request,
    input wire logic [7:0] reg_rd_data
);
    initial reg_request <= '0;

    // ========
    // Single byte accesses; released fields show inverted values
    task automatic write_reg(input logic [7:0] addr, data);
        @(posedge clock);
        reg_request <= '{addr, data, 1'b1, 1'b0};
        @(posedge clock);
        reg_request <= '{~addr, ~data, 1'b0, 1'b0};
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clock);
        reg_request <= '{addr, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        reg_request <= '{~addr, 8'hFF, 1'b0, 1'b0};
        #1;
        data = reg_rd_data;
    endtask
endmodule

// *** sim/monitor_config_registers_tb.sv ***
`timescale 1ns/10ps
module monitor_config_registers_tb
    import monitor_pkg::*;
;
    localparam int unsigned PULSE = 20;
    logic clock = 1'b0;
    logic sys_rst;
    reg_request_type reg_request;
    logic [7:0] reg_rd_data;
    logic [7:0] serial_bus_address;
    logic [7:0] rd;
    logic [3:0] cpu_voltage_code;
    logic [3:0] tach_phase = 4'h0;
    logic cpu_voltage_code_bit4, addr_select_low, addr_select_high;
    logic first_tach_input, second_tach_input, intrusion_detect_pin_out;
    logic intrusion_detect_pin_oe, intrusion_flag_clear;
    logic temp_error_flag, system_mgmt_alert;
    logic first_fan_pulse, second_fan_pulse;
    wire logic intrusion_detect_pin_in;
    temp_sample_type temp_sample;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int n1;
    int n2;

    always #5 clock = ~clock;
    // Pin is pulled up and only pulled low by the device
    assign intrusion_detect_pin_in = ~intrusion_detect_pin_oe;

    monitor_config_registers #(.INTRUSION_PULSE_CYCLES(PULSE)) u_dut (
        .clock(clock), .sys_rst(sys_rst), .reg_request(reg_request),
        .reg_rd_data(reg_rd_data), .serial_bus_address(serial_bus_address),
        .cpu_voltage_code(cpu_voltage_code),
        .cpu_voltage_code_bit4(cpu_voltage_code_bit4),
        .addr_select_low(addr_select_low), .addr_select_high(addr_select_high),
        .first_tach_input(first_tach_input),
        .second_tach_input(second_tach_input),
        .intrusion_detect_pin_in(intrusion_detect_pin_in),
        .intrusion_detect_pin_out(intrusion_detect_pin_out),
        .intrusion_detect_pin_oe(intrusion_detect_pin_oe),
        .intrusion_flag_clear(intrusion_flag_clear), .temp_sample(temp_sample),
        .temp_error_flag(temp_error_flag),
        .system_mgmt_alert(system_mgmt_alert),
        .first_fan_pulse(first_fan_pulse), .second_fan_pulse(second_fan_pulse)
    );
    host_model u_host (
        .clock(clock), .reg_request(reg_request), .reg_rd_data(reg_rd_data)
    );

    // ========
    // Tach edges every 16 cycles, timeout
    always @(posedge clock) begin
        tach_phase <= tach_phase + 4'h1;
        first_tach_input <= tach_phase[3];
        second_tach_input <= ~tach_phase[3];
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            tally_and_finish();
        end
    end

    // ========
    // Checking tasks
    task automatic check(input string name, input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rd_chk(input logic [7:0] addr, exp, input string name);
        u_host.read_reg(addr, rd);
        check(name, rd, exp);
    endtask

    task automatic fan_count(input logic [1:0] sel);
        int e;
        e = 64 >> sel;
        repeat (200) @(posedge clock);
        n1 = 0;
        n2 = 0;
        repeat (1024) begin
            @(posedge clock);
            #1;
            n1 += first_fan_pulse;
            n2 += second_fan_pulse;
        end
        check("fan one count", {7'h0, n1 >= e - 1 && n1 <= e + 1}, 8'h01);
        check("fan two count", {7'h0, n2 >= e - 1 && n2 <= e + 1}, 8'h01);
    endtask

    // Expected is {flag, alert} one cycle after the conversion is driven
    task automatic temp_step(input logic [7:0] deg, input logic half,
                             input logic [1:0] exp);
        @(posedge clock);
        temp_sample <= {1'b1, deg, half};
        @(posedge clock);
        temp_sample <= {1'b0, ~deg, ~half};
        #1;
        check("flag and alert", {6'h0, temp_error_flag, system_mgmt_alert},
              {6'h0, exp});
    endtask

    task automatic status_read(input logic [1:0] exp);
        rd_chk(8'h41, {3'h0, exp[1], 4'h0}, "status one");
        check("after status read", {6'h0, temp_error_flag, system_mgmt_alert},
              8'h00);
    endtask

    task automatic tally_and_finish();
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ========
    // Main sequence
    initial begin
        sys_rst <= 1'b1;
        cpu_voltage_code <= 4'hA;
        cpu_voltage_code_bit4 <= 1'b1;
        addr_select_high <= 1'b1;
        addr_select_low <= 1'b0;
        temp_sample <= '0;
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clock);
        rd_chk(8'h48, 8'h2E, "bus address");
        rd_chk(8'h49, 8'h81, "code bit4 reg");
        rd_chk(8'h4B, 8'h01, "temp config");
        rd_chk(8'h47, 8'h0A, "code and divisors");
        rd_chk(8'h46, 8'h00, "intrusion clear");
        u_host.write_reg(8'h47, 8'hF5);
        rd_chk(8'h47, 8'hFA, "divisor write");
        u_host.write_reg(8'h49, 8'h00);
        rd_chk(8'h49, 8'h01, "spare write");
        u_host.write_reg(8'h48, 8'h5A);
        rd_chk(8'h48, 8'h5A, "bus address write");
        check("bus address out", serial_bus_address, 8'h5A);
        for (int d = 0; d < 4; d++) begin
            u_host.write_reg(8'h47, {d[1:0], d[1:0], 4'h0});
            fan_count(d[1:0]);
        end
        u_host.write_reg(8'h46, 8'h80);
        #1;
        check("pin drive", {7'h0, intrusion_detect_pin_oe}, 8'h01);
        n1 = 0;
        while (intrusion_detect_pin_oe !== 1'b0 && n1 < 1000) begin
            @(posedge clock);
            #1;
            n1++;
        end
        check("pulse length", {7'h0, n1 >= PULSE}, 8'h01);
        rd_chk(8'h46, 8'h00, "self clear");
        u_host.write_reg(8'h39, 8'h28);
        u_host.write_reg(8'h3A, 8'h1E);
        // Both equal encodings select the default mode
        for (int m = 0; m < 4; m += 3) begin
            u_host.write_reg(8'h4B, m[7:0]);
            temp_step(8'd50, 1'b0, 2'b10);
            status_read(2'b10);
            temp_step(8'd35, 1'b0, 2'b10);
            status_read(2'b10);
            temp_step(8'd20, 1'b0, 2'b00);
            temp_step(8'd35, 1'b0, 2'b00);
        end
        u_host.write_reg(8'h4B, 8'h01);
        temp_step(8'd50, 1'b0, 2'b10);
        temp_step(8'd50, 1'b0, 2'b10);
        status_read(2'b10);
        temp_step(8'd50, 1'b0, 2'b00);
        temp_step(8'd35, 1'b0, 2'b00);
        temp_step(8'd20, 1'b0, 2'b10);
        status_read(2'b10);
        temp_step(8'd20, 1'b0, 2'b00);
        temp_step(8'd50, 1'b0, 2'b10);
        u_host.write_reg(8'h4B, 8'h02);
        status_read(2'b11);
        temp_step(8'd50, 1'b0, 2'b11);
        temp_step(8'd35, 1'b0, 2'b00);
        temp_step(8'd50, 1'b0, 2'b11);
        status_read(2'b11);
        temp_step(8'h28, 1'b1, 2'b00);
        rd_chk(8'h4B, 8'h82, "ninth bit");
        u_host.write_reg(8'h4B, 8'h7E);
        rd_chk(8'h4B, 8'hFE, "config write");
        tally_and_finish();
    end
endmodule
